// ===== hdl/tte_pkg.sv
package tte_pkg;

	// Byte offsets
	localparam logic [7:0] OFS_UNIT_CONTROL   = 8'h00;
	localparam logic [7:0] OFS_RELATIVE_LEVEL = 8'h0C;
	localparam logic [7:0] OFS_LEVEL_SMOOTH   = 8'h14;
	localparam logic [7:0] OFS_THRESHOLD      = 8'h18;
	localparam logic [7:0] OFS_PIN_SELECT     = 8'h1C;
	localparam logic [7:0] OFS_DMA_PORT       = 8'h20;
	localparam logic [7:0] OFS_STATUS         = 8'h24;
	localparam logic [7:0] OFS_IRQ_SET        = 8'h28;
	localparam logic [7:0] OFS_IRQ_CLEAR      = 8'h2C;
	localparam logic [7:0] OFS_IRQ_STATE      = 8'h30;
	localparam logic [7:0] OFS_STATUS_CLEAR   = 8'h34;
	localparam logic [7:0] OFS_TOUCH_ON_WORD  = 8'h40;
	localparam logic [7:0] OFS_TOUCH_ON_CLEAR = 8'h50;

	// Reset values
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// Sizes of this configuration
	localparam int NUM_PINS     = 16;
	localparam int PIN_BITS     = 4;
	localparam int NUM_WORDS    = 2;
	localparam int INDEX_BITS   = 6;
	localparam int FRAC_IMPL    = 8;
	localparam int SMOOTH_IMPL  = 4;
	localparam int LEVEL_BITS   = 20;

	// Threshold register fields
	localparam int THR_LEN_LSB  = 24;
	localparam int THR_LEN_BITS = 5;
	localparam int THR_DIR_BIT  = 23;
	localparam int THR_VAL_BITS = 20;

	// Control register fields
	localparam int CTL_DIFF_BIT = 0;
	localparam int CTL_DMA_BIT  = 1;

	// Status field positions
	localparam int ST_SAMPLE = 0;
	localparam int ST_ON     = 1;
	localparam int ST_OFF    = 2;
	localparam int ST_BITS   = 3;

	// Implemented masks
	localparam logic [31:0] THR_MASK    = 32'h1F8F_FFF0;
	localparam logic [31:0] SMOOTH_MASK = 32'h0000_0F00;
	localparam logic [31:0] PIN_MASK    = 32'h0000_000F;
	localparam logic [31:0] CTL_MASK    = 32'h0000_0003;

	typedef enum logic [0:0] {
		TTE_UNTOUCHED = 1'b0,
		TTE_TOUCHED   = 1'b1
	} tte_touch_state_t;

	typedef struct packed {
		logic       write;
		logic [7:0] addr;
	} tte_addr_phase_t;

	typedef struct packed {
		logic                  valid;
		logic [LEVEL_BITS-1:0] value;
		logic [INDEX_BITS-1:0] index;
	} tte_sample_t;

endpackage

// ===== hdl/tte_touch_threshold_event_regs.sv
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Event only after LENGTH consecutive beyond-threshold samples
// - Direction 0 above touches, 1 below
// - Threshold integer plus partly implemented fraction
// - Smoothing field scales the level averaging filter
// - Pin select; differential selects m and m+1, m alone for the last pin
// - Only needed pin select bits implemented
// - Status bit 2 off-touch, bit 1 on-touch
// - Status bit 0 on new measurement
// - Status read-only, cleared by clear-register ones
// - Status clear also withdraws interrupt request
// - Enable-set ones set mask bits
// - Enable-clear ones clear mask bits
// - Zero writes change nothing
// - Mask register shows enabled sources
// - Read-only touch-on words, reset zero
// - DMA mode on-touch sets selected word bit
// - Touch-on clear word ones clear bits
module tte_touch_threshold_event_regs (
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output var  logic [31:0]          hrdata,
	output var  logic                 hreadyout,
	output var  logic                 hresp,
	input  wire tte_pkg::tte_sample_t sample_in,
	output var  logic [15:0]          sense_select,
	output var  logic                 irq
);

	function automatic logic beyond(input logic [19:0] lvl, input logic [19:0] thr,
		input logic dir, input logic touched);
		logic hit;
		hit = dir ? (lvl < thr) : (lvl > thr);
		beyond = touched ? !hit : hit;
	endfunction

	function automatic logic [7:0] word_ofs(input logic [7:0] a);
		word_ofs = {a[7:2], 2'b00};
	endfunction

	tte_pkg::tte_addr_phase_t       aph;
	tte_pkg::tte_addr_phase_t       next_aph;
	logic                           data_wr;
	logic                           next_data_wr;
	logic [31:0]                    next_hrdata;
	logic [31:0]                    unit_control;
	logic [31:0]                    next_unit_control;
	logic [31:0]                    level_smooth;
	logic [31:0]                    next_level_smooth;
	logic [31:0]                    touch_threshold;
	logic [31:0]                    next_touch_threshold;
	logic [31:0]                    sense_pin_select;
	logic [31:0]                    next_sense_pin_select;
	logic [31:0]                    dma_transfer_port;
	logic [31:0]                    next_dma_transfer_port;
	logic [2:0]                     event_status;
	logic [2:0]                     next_event_status;
	logic [2:0]                     irq_mask;
	logic [2:0]                     next_irq_mask;
	logic [31:0]                    touch_on_word [tte_pkg::NUM_WORDS];
	logic [31:0]                    next_touch_on_word [tte_pkg::NUM_WORDS];
	logic [19:0]                    rel_level;
	logic [19:0]                    next_rel_level;
	tte_pkg::tte_touch_state_t      touch_state;
	tte_pkg::tte_touch_state_t      next_touch_state;
	logic [4:0]                     run_count;
	logic [4:0]                     next_run_count;
	logic                           next_irq;
	logic [15:0]                    next_sense_select;

	logic                           take;
	logic signed [20:0]             diff;
	logic signed [20:0]             step;
	logic [19:0]                    filtered;
	logic [19:0]                    thr_value;
	logic [4:0]                     need;
	logic                           event_hit;
	logic [2:0]                     ev_set;
	logic [2:0]                     ev_clr;
	logic [3:0]                     pin_m;
	logic [7:0]                     wr_ofs;

	assign take = hsel && hready && htrans[1];
	assign thr_value = touch_threshold[tte_pkg::THR_VAL_BITS-1:0];
	assign pin_m = sense_pin_select[tte_pkg::PIN_BITS-1:0];
	assign wr_ofs = word_ofs(aph.addr);

	// Sense pin decoder; the last pin has no upper partner
	for (genvar p = 0; p < tte_pkg::NUM_PINS; p++) begin : g_pin
		if (p == 0) begin : g_first
			assign next_sense_select[p] = (pin_m == 4'(p));
		end else begin : g_rest
			assign next_sense_select[p] = (pin_m == 4'(p)) ||
				(unit_control[tte_pkg::CTL_DIFF_BIT] && (pin_m == 4'(p - 1)));
		end
	end

	// Bus address phase and read data
	always_comb begin
		next_aph = aph;
		next_data_wr = 1'b0;
		next_hrdata = hrdata;
		if (take) begin
			next_aph.write = hwrite;
			next_aph.addr = haddr[7:0];
			next_data_wr = hwrite;
			if (!hwrite) begin
				case (word_ofs(haddr[7:0]))
					tte_pkg::OFS_UNIT_CONTROL: begin
						next_hrdata = unit_control;
					end
					tte_pkg::OFS_RELATIVE_LEVEL: begin
						next_hrdata = {12'h000, rel_level};
					end
					tte_pkg::OFS_LEVEL_SMOOTH: begin
						next_hrdata = level_smooth;
					end
					tte_pkg::OFS_THRESHOLD: begin
						next_hrdata = touch_threshold;
					end
					tte_pkg::OFS_PIN_SELECT: begin
						next_hrdata = sense_pin_select;
					end
					tte_pkg::OFS_DMA_PORT: begin
						next_hrdata = dma_transfer_port;
					end
					tte_pkg::OFS_STATUS: begin
						next_hrdata = {29'h0, event_status};
					end
					tte_pkg::OFS_IRQ_STATE: begin
						next_hrdata = {29'h0, irq_mask};
					end
					tte_pkg::OFS_TOUCH_ON_WORD: begin
						next_hrdata = touch_on_word[0];
					end
					tte_pkg::OFS_TOUCH_ON_WORD + 8'h04: begin
						next_hrdata = touch_on_word[1];
					end
					default: begin
						next_hrdata = tte_pkg::RST_WORD;
					end
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aph <= '0;
			data_wr <= 1'b0;
			hrdata <= tte_pkg::RST_WORD;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			aph <= next_aph;
			data_wr <= next_data_wr;
			hrdata <= next_hrdata;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Configuration and mask registers; zero bits of set and clear writes leave the mask alone
	always_comb begin
		next_unit_control = unit_control;
		next_level_smooth = level_smooth;
		next_touch_threshold = touch_threshold;
		next_sense_pin_select = sense_pin_select;
		next_dma_transfer_port = dma_transfer_port;
		next_irq_mask = irq_mask;
		if (data_wr) begin
			case (wr_ofs)
				tte_pkg::OFS_UNIT_CONTROL: begin
					next_unit_control = hwdata & tte_pkg::CTL_MASK;
				end
				tte_pkg::OFS_LEVEL_SMOOTH: begin
					next_level_smooth = hwdata & tte_pkg::SMOOTH_MASK;
				end
				tte_pkg::OFS_THRESHOLD: begin
					next_touch_threshold = hwdata & tte_pkg::THR_MASK;
				end
				tte_pkg::OFS_PIN_SELECT: begin
					next_sense_pin_select = hwdata & tte_pkg::PIN_MASK;
				end
				tte_pkg::OFS_DMA_PORT: begin
					next_dma_transfer_port = hwdata;
				end
				tte_pkg::OFS_IRQ_SET: begin
					next_irq_mask = irq_mask | hwdata[2:0];
				end
				tte_pkg::OFS_IRQ_CLEAR: begin
					next_irq_mask = irq_mask & ~hwdata[2:0];
				end
				default: begin
					next_unit_control = unit_control;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			unit_control <= tte_pkg::RST_WORD;
			level_smooth <= tte_pkg::RST_WORD;
			touch_threshold <= tte_pkg::RST_WORD;
			sense_pin_select <= tte_pkg::RST_WORD;
			dma_transfer_port <= tte_pkg::RST_WORD;
			irq_mask <= 3'b000;
		end else begin
			unit_control <= next_unit_control;
			level_smooth <= next_level_smooth;
			touch_threshold <= next_touch_threshold;
			sense_pin_select <= next_sense_pin_select;
			dma_transfer_port <= next_dma_transfer_port;
			irq_mask <= next_irq_mask;
		end
	end

	// Level smoothing filter
	always_comb begin
		next_rel_level = rel_level;
		diff = $signed({1'b0, sample_in.value}) - $signed({1'b0, rel_level});
		step = diff >>> level_smooth[8 +: tte_pkg::SMOOTH_IMPL];
		filtered = rel_level + step[19:0];
		if (sample_in.valid) begin
			next_rel_level = filtered;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rel_level <= 20'h0_0000;
		end else begin
			rel_level <= next_rel_level;
		end
	end

	// Successive-sample counter
	always_comb begin
		next_run_count = run_count;
		event_hit = 1'b0;
		need = touch_threshold[tte_pkg::THR_LEN_LSB +: tte_pkg::THR_LEN_BITS];
		if (need == 5'd0) begin
			need = 5'd1;
		end
		if (sample_in.valid) begin
			if (beyond(filtered, thr_value, touch_threshold[tte_pkg::THR_DIR_BIT],
				touch_state == tte_pkg::TTE_TOUCHED)) begin
				if (run_count + 5'd1 >= need) begin
					event_hit = 1'b1;
					next_run_count = 5'd0;
				end else begin
					next_run_count = run_count + 5'd1;
				end
			end else begin
				next_run_count = 5'd0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_count <= 5'd0;
		end else begin
			run_count <= next_run_count;
		end
	end

	// Touch state
	always_comb begin
		next_touch_state = touch_state;
		if (event_hit) begin
			case (touch_state)
				tte_pkg::TTE_UNTOUCHED: begin
					next_touch_state = tte_pkg::TTE_TOUCHED;
				end
				tte_pkg::TTE_TOUCHED: begin
					next_touch_state = tte_pkg::TTE_UNTOUCHED;
				end
				default: begin
					next_touch_state = tte_pkg::TTE_UNTOUCHED;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			touch_state <= tte_pkg::TTE_UNTOUCHED;
		end else begin
			touch_state <= next_touch_state;
		end
	end

	// Status flags, touch-on words and interrupt
	always_comb begin
		ev_set = 3'b000;
		ev_clr = 3'b000;
		next_touch_on_word = touch_on_word;
		ev_set[tte_pkg::ST_SAMPLE] = sample_in.valid;
		ev_set[tte_pkg::ST_ON] = event_hit && (touch_state == tte_pkg::TTE_UNTOUCHED);
		ev_set[tte_pkg::ST_OFF] = event_hit && (touch_state == tte_pkg::TTE_TOUCHED);
		if (data_wr) begin
			case (wr_ofs)
				tte_pkg::OFS_STATUS_CLEAR: begin
					ev_clr = hwdata[2:0];
				end
				tte_pkg::OFS_TOUCH_ON_CLEAR: begin
					next_touch_on_word[0] = touch_on_word[0] & ~hwdata;
				end
				tte_pkg::OFS_TOUCH_ON_CLEAR + 8'h04: begin
					next_touch_on_word[1] = touch_on_word[1] & ~hwdata;
				end
				default: begin
					ev_clr = 3'b000;
				end
			endcase
		end
		// New events win over a same-cycle clear
		if (ev_set[tte_pkg::ST_ON] && unit_control[tte_pkg::CTL_DMA_BIT]) begin
			next_touch_on_word[sample_in.index[5]][sample_in.index[4:0]] = 1'b1;
		end
		next_event_status = (event_status & ~ev_clr) | ev_set;
		next_irq = |(next_event_status & next_irq_mask);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			event_status <= 3'b000;
			touch_on_word[0] <= tte_pkg::RST_WORD;
			touch_on_word[1] <= tte_pkg::RST_WORD;
			irq <= 1'b0;
		end else begin
			event_status <= next_event_status;
			touch_on_word <= next_touch_on_word;
			irq <= next_irq;
		end
	end

	// Pin enable output
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sense_select <= 16'h0000;
		end else begin
			sense_select <= next_sense_select;
		end
	end

endmodule

`default_nettype wire

// ===== verif/tte_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
module tte_chk_sva (
	input wire logic                 hclk,
	input wire logic                 hresetn,
	input wire logic                 hsel,
	input wire logic [31:0]          haddr,
	input wire logic [1:0]           htrans,
	input wire logic                 hwrite,
	input wire logic [31:0]          hwdata,
	input wire logic                 hready,
	input wire logic [31:0]          hrdata,
	input wire tte_pkg::tte_sample_t sample_in,
	input wire logic [15:0]          sense_select,
	input wire logic                 irq
);
	logic       dp_wr;
	logic       dp_rd;
	logic [7:0] dp_addr;
	wire        take = hsel && hready && htrans[1];
	// Data phase tracker
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr   <= 1'b0;
			dp_rd   <= 1'b0;
			dp_addr <= 8'h00;
		end else begin
			dp_wr   <= take && hwrite;
			dp_rd   <= take && !hwrite;
			dp_addr <= haddr[7:0];
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_wr(logic [7:0] a);
		dp_wr && dp_addr == a && !sample_in.valid;
	endsequence
	sequence s_rd(logic [7:0] a);
		dp_rd && dp_addr == a;
	endsequence
	AST_IRQ_RISE: assert property ($rose(irq) |-> $past(sample_in.valid) || $past(dp_wr))
		else $error("irq rose without sample or write");
	AST_IRQ_FALL: assert property ($fell(irq) |-> $past(dp_wr))
		else $error("irq fell without write");
	AST_CLR_WITHDRAW: assert property (s_wr(8'h34) ##0 hwdata[2:0] == 3'h7 |=> !irq)
		else $error("irq stayed after status clear");
	AST_DISABLE: assert property (s_wr(8'h2C) ##0 hwdata[2:0] == 3'h7 |=> !irq)
		else $error("irq stayed after mask clear");
	AST_ZERO_WRITE: assert property (
		(s_wr(8'h28) or s_wr(8'h2C) or s_wr(8'h34)) ##0 hwdata == 32'h0000_0000 |=> $stable(irq))
		else $error("zero write changed irq");
	AST_PIN_HOT: assert property (
		$past(hresetn) |-> $countones(sense_select) inside {1, 2})
		else $error("sense select not one or two hot");
	AST_STATUS_BITS: assert property (s_rd(8'h24) |-> hrdata[31:3] == 29'h0)
		else $error("status upper bits set");
	AST_THR_MASK: assert property (s_rd(8'h18) |-> (hrdata & ~tte_pkg::THR_MASK) == 0)
		else $error("threshold unimplemented bits set");
	AST_PIN_WIDTH: assert property (s_rd(8'h1C) |-> hrdata[31:4] == 28'h0)
		else $error("pin select too wide");
	AST_WO_READ: assert property (
		dp_rd && dp_addr inside {8'h28, 8'h2C, 8'h34} |-> hrdata == 32'h0000_0000)
		else $error("write-only register read nonzero");
endmodule
`default_nettype wire

// ===== verif/tte_pad_model.sv
`timescale 1ns/100ps
`default_nettype none
module tte_pad_model (
	input  wire logic                 hclk,
	input  wire logic [15:0]          sense_select,
	output var  tte_pkg::tte_sample_t sample_in
);
	initial sample_in = '0;
	// Gap cycles give prompt or slow pads
	task send(input logic [19:0] v, input logic [5:0] i, input int gap);
		repeat (gap) @(posedge hclk);
		@(posedge hclk);
		sample_in <= {|sense_select, v, i};
		@(posedge hclk);
		// Idle lines show the inverse, not a held value
		sample_in <= {1'b0, ~v, ~i};
	endtask
endmodule
`default_nettype wire

// ===== verif/tte_touch_threshold_event_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tte_touch_threshold_event_regs_tb_top;
	logic                 hclk = 1'b0;
	logic                 hresetn = 1'b0;
	logic                 hsel = 1'b0;
	logic [31:0]          haddr = 32'h0000_0000;
	logic [1:0]           htrans = 2'h0;
	logic                 hwrite = 1'b0;
	logic [2:0]           hsize = 3'h2;
	logic [31:0]          hwdata = 32'h0000_0000;
	logic [31:0]          hrdata;
	logic                 hreadyout;
	logic                 hresp;
	tte_pkg::tte_sample_t sample_in;
	logic [15:0]          sense_select;
	logic                 irq;
	wire                  hready = hreadyout;
	int                   mismatches = 0;
	int                   n_compared = 0;
	int                   cyc = 0;
	logic [7:0]           ra [8] = '{8'h18, 8'h1C, 8'h24, 8'h30, 8'h40, 8'h44, 8'h3C, 8'h28};
	tte_touch_threshold_event_regs tte_touch_threshold_event_regs_inst (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .sample_in(sample_in),
		.sense_select(sense_select), .irq(irq));
	tte_pad_model tte_pad_model_inst (
		.hclk(hclk), .sense_select(sense_select), .sample_in(sample_in));
	always #5 hclk = ~hclk;
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			mismatches++;
			wrap_up();
		end
	end
	task wrap_up;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= 32'(a);
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0000_0000, q);
		chk($sformatf("reg %h", a), e, q);
		chk("hresp", 32'h0000_0000, 32'(hresp));
	endtask
	task sel(input logic [15:0] e);
		repeat (2) @(posedge hclk);
		#1 chk("sense_select", 32'(e), 32'(sense_select));
	endtask
	task sig(input logic e);
		#1 chk("irq", 32'(e), 32'(irq));
	endtask
	task snd(input logic [19:0] v, input logic [5:0] i, input int gap);
		tte_pad_model_inst.send(v, i, gap);
	endtask
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		// DMA port is never touched by software
		foreach (ra[i]) rc(ra[i], 32'h0000_0000);
		sel(16'h0001);
		wr(8'h1C, 32'h0000_0003);
		sel(16'h0008);
		wr(8'h00, 32'h0000_0001);
		sel(16'h0018);
		wr(8'h1C, 32'h0000_00FF);
		rc(8'h1C, 32'h0000_000F);
		sel(16'h8000);
		wr(8'h28, 32'h0000_0007);
		rc(8'h30, 32'h0000_0007);
		wr(8'h2C, 32'h0000_0002);
		rc(8'h30, 32'h0000_0005);
		wr(8'h28, 32'h0000_0000);
		wr(8'h2C, 32'h0000_0000);
		rc(8'h30, 32'h0000_0005);
		wr(8'h28, 32'h0000_0002);
		wr(8'h18, 32'hFFFF_FFFF);
		rc(8'h18, 32'h1F8F_FFF0);
		wr(8'h18, 32'h0200_1000);
		wr(8'h00, 32'h0000_0003);
		snd(20'h0_2000, 6'd42, 0);
		rc(8'h24, 32'h0000_0001);
		sig(1'b1);
		snd(20'h0_0000, 6'd42, 3);
		snd(20'h0_2000, 6'd42, 0);
		rc(8'h24, 32'h0000_0001);
		snd(20'h0_2000, 6'd42, 1);
		rc(8'h24, 32'h0000_0003);
		rc(8'h44, 32'h0000_0400);
		wr(8'h24, 32'h0000_0000);
		rc(8'h24, 32'h0000_0003);
		wr(8'h54, 32'h0000_0400);
		rc(8'h44, 32'h0000_0000);
		snd(20'h0_0000, 6'd42, 0);
		snd(20'h0_0000, 6'd42, 0);
		rc(8'h24, 32'h0000_0007);
		wr(8'h34, 32'h0000_0000);
		rc(8'h24, 32'h0000_0007);
		wr(8'h34, 32'h0000_0007);
		rc(8'h24, 32'h0000_0000);
		sig(1'b0);
		wr(8'h18, 32'h0180_1000);
		snd(20'h0_0000, 6'd0, 0);
		rc(8'h24, 32'h0000_0003);
		wr(8'h14, 32'h0000_0100);
		snd(20'h0_2000, 6'd0, 2);
		rc(8'h0C, 32'h0000_1000);
		wrap_up();
	end
endmodule
bind tte_touch_threshold_event_regs tte_chk_sva tte_chk_sva_inst (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .sample_in(sample_in),
	.sense_select(sense_select), .irq(irq));
`default_nettype wire
